/* core/romc_pkg.sv */
// Constants shared by the operating-mode controller and its command deframer
package romc_pkg;

   // Clock rate
   localparam int CLK_MHZ = 100;

   // Reported state codes
   localparam logic [6:0] CODE_STANDBY  = 7'h40;
   localparam logic [6:0] CODE_SLEEP    = 7'h36;
   localparam logic [6:0] CODE_READY    = 7'h03;
   localparam logic [6:0] CODE_LOCK     = 7'h0F;
   localparam logic [6:0] CODE_RX       = 7'h33;
   localparam logic [6:0] CODE_TX       = 7'h5F;
   localparam logic [6:0] CODE_SHUTDOWN = 7'h00;

   // Command transfer layout
   localparam logic [7:0] CMD_HEADER    = 8'h80;
   localparam logic [7:0] CMD_TX        = 8'h60;
   localparam logic [7:0] CMD_RX        = 8'h61;
   localparam logic [7:0] CMD_READY     = 8'h62;
   localparam logic [7:0] CMD_STANDBY   = 8'h63;
   localparam logic [7:0] CMD_SLEEP     = 8'h64;
   localparam logic [7:0] CMD_LOCK_RX   = 8'h65;
   localparam logic [7:0] CMD_LOCK_TX   = 8'h66;
   localparam logic [7:0] CMD_ABORT     = 8'h67;

   // Timing
   localparam int STARTUP_TIME_US       = 650;
   localparam int STARTUP_CYCLES_DEF    = STARTUP_TIME_US * CLK_MHZ;
   localparam int LOCK_TIMEOUT_US       = 80;
   localparam int LOCK_TIMEOUT_CYC_DEF  = LOCK_TIMEOUT_US * CLK_MHZ;
   localparam int CNT_W                 = 17;

   // Reset values
   localparam logic [6:0] CAL_RESET     = 7'h00;

   // Controller states
   typedef enum logic [2:0] {
      ST_SHUTDOWN,
      ST_STARTUP,
      ST_READY,
      ST_STANDBY,
      ST_SLEEP,
      ST_LOCK,
      ST_RX,
      ST_TX
   } romc_state_type;

endpackage

/* core/romc_cmd_deframer.sv */
// Turns header plus code byte pairs from the serial port into command pulses
`timescale 1ns/1ps
`default_nettype none
module romc_cmd_deframer
   import romc_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       nrst_in,
   // Byte stream
   input  wire logic       spi_cs_n_in,
   input  wire logic       spi_byte_valid_in,
   input  wire logic [7:0] spi_byte_in,
   // Command out
   output logic            cmd_valid_out,
   output logic [7:0]      cmd_code_out
);

   typedef enum logic [1:0] {
      DF_HEADER,
      DF_CODE,
      DF_SKIP
   } romc_df_type;

   romc_df_type df_reg;
   romc_df_type df_next;
   logic        fire;

   always_comb begin
      df_next = df_reg;
      unique case (df_reg)
         DF_HEADER: begin
            if (spi_byte_valid_in) begin
               df_next = (spi_byte_in == CMD_HEADER) ? DF_CODE : DF_SKIP;
            end
         end
         DF_CODE: begin
            if (spi_byte_valid_in) begin
               df_next = DF_HEADER;
            end
         end
         DF_SKIP: begin
            df_next = DF_SKIP;
         end
         // Unused encoding falls back to header hunt
         default: begin
            df_next = DF_HEADER;
         end
      endcase
      // Other accesses have unknown length, so resync on deselect
      if (spi_cs_n_in) begin
         df_next = DF_HEADER;
      end
   end

   assign fire = !spi_cs_n_in && spi_byte_valid_in && (df_reg == DF_CODE);

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         df_reg        <= DF_HEADER;
         cmd_valid_out <= 1'b0;
         cmd_code_out  <= 8'h00;
      end else begin
         df_reg        <= df_next;
         cmd_valid_out <= fire;
         if (fire) begin
            cmd_code_out <= spi_byte_in;
         end
      end
   end

endmodule
`default_nettype wire

/* core/romc_mode_ctrl.sv */
// Operating-mode state machine of the radio transceiver
`timescale 1ns/1ps
`default_nettype none
module romc_mode_ctrl
   import romc_pkg::*;
#(
   parameter int STARTUP_CYCLES      = STARTUP_CYCLES_DEF,
   parameter int LOCK_TIMEOUT_CYCLES = LOCK_TIMEOUT_CYC_DEF
)(
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       nrst_in,
   // Shutdown pin
   input  wire logic       shutdown_pin_in,
   // Serial command byte stream
   input  wire logic       spi_cs_n_in,
   input  wire logic       spi_byte_valid_in,
   input  wire logic [7:0] spi_byte_in,
   // Radio events
   input  wire logic       synth_lock_in,
   input  wire logic       tx_done_in,
   input  wire logic       rx_done_in,
   input  wire logic       rx_timeout_in,
   input  wire logic       auto_turnaround_in,
   input  wire logic       ldcr_mode_in,
   // Wake-up
   input  wire logic       wakeup_in,
   input  wire logic       pending_tx_in,
   input  wire logic       pending_rx_in,
   // Battery monitor
   input  wire logic       low_batt_in,
   input  wire logic       batt_guard_en_in,
   // Synthesizer calibration
   input  wire logic [6:0] synth_cal_in,
   // State report
   output logic [6:0]      state_code_out,
   output logic            state_error_out,
   output logic            lock_held_out,
   output logic            cmd_ignored_out,
   // Supplies and pins
   output logic            supply_on_out,
   output logic            pins_oe_out,
   // Analog block enables
   output logic            crystal_osc_on_out,
   output logic            synth_on_out,
   output logic            wakeup_timer_on_out,
   output logic            rx_chain_on_out,
   output logic            power_amplifier_on_out,
   // Calibration word
   output logic [6:0]      synth_cal_result_out,
   output logic            synth_cal_valid_out
);

   // Code for each state
   function automatic logic [6:0] code_of(input romc_state_type s);
      logic [6:0] c;
      c = CODE_SHUTDOWN;
      unique case (s)
         ST_SHUTDOWN: c = CODE_SHUTDOWN;
         ST_STARTUP:  c = CODE_SHUTDOWN;
         ST_READY:    c = CODE_READY;
         ST_STANDBY:  c = CODE_STANDBY;
         ST_SLEEP:    c = CODE_SLEEP;
         ST_LOCK:     c = CODE_LOCK;
         ST_RX:       c = CODE_RX;
         ST_TX:       c = CODE_TX;
      endcase
      return c;
   endfunction
   // Check a code against the six defined codes other than the shutdown code
   function automatic logic code_valid(input logic [6:0] c);
      return (c == CODE_STANDBY) || (c == CODE_SLEEP) || (c == CODE_READY) ||
             (c == CODE_LOCK) || (c == CODE_RX) || (c == CODE_TX);
   endfunction
   romc_state_type   state_reg;
   romc_state_type   state_next;
   logic             hold_reg;
   logic             hold_next;
   logic             tgt_tx_reg;
   logic             tgt_tx_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic             cmd_fire;
   logic [7:0]       cmd_code;
   logic             ignored_next;
   logic [6:0]       code_next;
   logic             startup_end;
   logic             lock_timeout;
   logic             lock_reached;
   logic             pa_blocked;
   logic             in_shutdown;

   romc_cmd_deframer u_deframer (
      .clk_in            (clk_in),
      .nrst_in           (nrst_in),
      .spi_cs_n_in       (spi_cs_n_in),
      .spi_byte_valid_in (spi_byte_valid_in),
      .spi_byte_in       (spi_byte_in),
      .cmd_valid_out     (cmd_fire),
      .cmd_code_out      (cmd_code)
   );
   // Timer, lock, battery and next-state decodes
   assign startup_end  = (cnt_reg == CNT_W'(STARTUP_CYCLES - 1));
   assign lock_timeout = (cnt_reg == CNT_W'(LOCK_TIMEOUT_CYCLES - 1));
   assign lock_reached = synth_lock_in || lock_timeout;
   assign pa_blocked   = low_batt_in && batt_guard_en_in;
   assign in_shutdown  = (state_next == ST_SHUTDOWN);
   assign code_next    = code_of(state_next);
   always_comb begin
      state_next   = state_reg;
      hold_next    = hold_reg;
      tgt_tx_next  = tgt_tx_reg;
      ignored_next = 1'b0;
      cnt_next     = cnt_reg;
      unique case (state_reg)
         ST_SHUTDOWN: begin
            cnt_next   = '0;
            state_next = ST_STARTUP;
         end
         ST_STARTUP: begin
            cnt_next = cnt_reg + CNT_W'(1);
            if (startup_end) begin
               state_next = ST_READY;
               hold_next  = 1'b1;
            end
         end
         ST_READY: begin
            if (!hold_reg) begin
               state_next = ST_LOCK;
               cnt_next   = '0;
            end else if (cmd_fire) begin
               unique case (cmd_code)
                  CMD_TX, CMD_RX: begin
                     state_next  = ST_LOCK;
                     hold_next   = 1'b0;
                     tgt_tx_next = (cmd_code == CMD_TX);
                     cnt_next    = '0;
                  end
                  CMD_LOCK_RX, CMD_LOCK_TX: begin
                     state_next  = ST_LOCK;
                     hold_next   = 1'b1;
                     tgt_tx_next = (cmd_code == CMD_LOCK_TX);
                     cnt_next    = '0;
                  end
                  CMD_STANDBY: state_next = ST_STANDBY;
                  CMD_SLEEP:   state_next = ST_SLEEP;
                  default:     ignored_next = 1'b1;
               endcase
            end
         end
         ST_STANDBY: begin
            if (cmd_fire) begin
               if (cmd_code == CMD_READY) begin
                  state_next = ST_READY;
                  hold_next  = 1'b1;
               end else begin
                  ignored_next = 1'b1;
               end
            end
         end
         ST_SLEEP: begin
            if (cmd_fire && (cmd_code == CMD_READY)) begin
               state_next = ST_READY;
               hold_next  = 1'b1;
            end else if (wakeup_in) begin
               state_next  = ST_READY;
               hold_next   = !(pending_tx_in || pending_rx_in);
               tgt_tx_next = pending_tx_in;
            end else if (cmd_fire) begin
               ignored_next = 1'b1;
            end
         end
         ST_LOCK: begin
            cnt_next = lock_timeout ? cnt_reg : cnt_reg + CNT_W'(1);
            if (hold_reg) begin
               if (cmd_fire) begin
                  if (cmd_code == CMD_READY) begin
                     state_next = ST_READY;
                  end else begin
                     ignored_next = 1'b1;
                  end
               end
            end else if (lock_reached) begin
               // active states entered only from lock
               state_next = tgt_tx_reg ? ST_TX : ST_RX;
            end else if (cmd_fire) begin
               ignored_next = 1'b1;
            end
         end
         ST_RX, ST_TX: begin
            if (cmd_fire && (cmd_code == CMD_ABORT)) begin
               state_next = ST_READY;
               hold_next  = 1'b1;
            end else if (auto_turnaround_in) begin
               state_next  = ST_LOCK;
               hold_next   = 1'b0;
               tgt_tx_next = (state_reg == ST_RX);
               cnt_next    = '0;
            end else if ((state_reg == ST_TX) && tx_done_in) begin
               state_next = ST_READY;
               hold_next  = 1'b1;
            end else if ((state_reg == ST_RX) && (rx_done_in || rx_timeout_in)) begin
               // receive ends in ready or sleep
               state_next = ldcr_mode_in ? ST_SLEEP : ST_READY;
               hold_next  = 1'b1;
            end else if (cmd_fire) begin
               ignored_next = 1'b1;
            end
         end
      endcase
      if (shutdown_pin_in) begin
         state_next   = ST_SHUTDOWN;
         hold_next    = 1'b1;
         tgt_tx_next  = 1'b0;
         cnt_next     = '0;
         ignored_next = 1'b0;
      end
   end

   // Reset starts like a shutdown release
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_reg  <= ST_STARTUP;
         hold_reg   <= 1'b1;
         tgt_tx_reg <= 1'b0;
         cnt_reg    <= '0;
      end else begin
         state_reg  <= state_next;
         hold_reg   <= hold_next;
         tgt_tx_reg <= tgt_tx_next;
         cnt_reg    <= cnt_next;
      end
   end

   // Outputs registered from the next state
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_code_out         <= CODE_SHUTDOWN;
         state_error_out        <= 1'b0;
         lock_held_out          <= 1'b0;
         cmd_ignored_out        <= 1'b0;
         supply_on_out          <= 1'b1;
         pins_oe_out            <= 1'b1;
         crystal_osc_on_out     <= 1'b1;
         synth_on_out           <= 1'b0;
         wakeup_timer_on_out    <= 1'b0;
         rx_chain_on_out        <= 1'b0;
         power_amplifier_on_out <= 1'b0;
      end else begin
         state_code_out         <= code_next;
         state_error_out        <= !code_valid(code_next) && !in_shutdown && (state_next != ST_STARTUP);
         lock_held_out          <= (state_next == ST_LOCK) && hold_next;
         cmd_ignored_out        <= ignored_next;
         supply_on_out          <= !in_shutdown;
         pins_oe_out            <= in_shutdown;
         crystal_osc_on_out     <= !in_shutdown && (state_next != ST_STANDBY) && (state_next != ST_SLEEP);
         synth_on_out           <= (state_next == ST_LOCK) || (state_next == ST_RX) || (state_next == ST_TX);
         wakeup_timer_on_out    <= (state_next == ST_SLEEP);
         rx_chain_on_out        <= (state_next == ST_RX);
         power_amplifier_on_out <= (state_next == ST_TX) && !pa_blocked;
      end
   end

   // Calibration word, lost at shutdown
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         synth_cal_result_out <= CAL_RESET;
         synth_cal_valid_out  <= 1'b0;
      end else if (in_shutdown) begin
         synth_cal_result_out <= CAL_RESET;
         synth_cal_valid_out  <= 1'b0;
      end else if ((state_reg == ST_LOCK) && hold_reg) begin
         synth_cal_result_out <= synth_cal_in;
         synth_cal_valid_out  <= 1'b1;
      end else begin
         synth_cal_valid_out  <= 1'b0;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   shutdown_float_a:
      assert property (state_reg == ST_SHUTDOWN |-> pins_oe_out && !supply_on_out && !synth_cal_valid_out)
      else $error("pins not floated in shutdown");
   startup_ready_a:
      assert property (state_reg == ST_STARTUP && startup_end && !shutdown_pin_in |=> state_reg == ST_READY)
      else $error("start-up did not end in ready");
   code_match_a:
      assert property (state_reg != ST_SHUTDOWN && state_reg != ST_STARTUP |-> state_code_out == code_of(state_reg))
      else $error("state code mismatch");
   code_error_a:
      assert property (state_error_out == (!code_valid(state_code_out) && state_code_out != CODE_SHUTDOWN))
      else $error("error flag disagrees with code");
   no_direct_turn_a:
      assert property (state_reg == ST_RX |=> state_reg != ST_TX)
      else $error("receive jumped to transmit");
   auto_lock_a:
      assert property (state_reg == ST_READY && hold_reg && cmd_fire && cmd_code == CMD_TX && !shutdown_pin_in
                       |=> state_reg == ST_LOCK && !hold_reg && tgt_tx_reg
                       ##1 (state_reg == ST_TX || !$past(synth_lock_in) || $past(shutdown_pin_in)))
      else $error("transmit command did not pass lock");
   lock_reach_a:
      assert property (state_reg == ST_LOCK && !hold_reg && lock_reached && tgt_tx_reg && !shutdown_pin_in
                       |=> state_reg == ST_TX)
      else $error("lock reached but transmit not entered");
   lock_hold_a:
      assert property (state_reg == ST_LOCK && hold_reg && !cmd_fire && !shutdown_pin_in |=> state_reg == ST_LOCK)
      else $error("held lock left without command");
   abort_ready_a:
      assert property ((state_reg == ST_TX || state_reg == ST_RX) && cmd_fire && cmd_code == CMD_ABORT
                       && !shutdown_pin_in |=> state_reg == ST_READY ##1 state_code_out == CODE_READY)
      else $error("abort did not return to ready");
   pa_guard_a:
      assert property (low_batt_in && batt_guard_en_in |=> !power_amplifier_on_out)
      else $error("amplifier on under low battery");
   ignore_cmd_a:
      assert property (state_reg == ST_STANDBY && cmd_fire && cmd_code != CMD_READY && !shutdown_pin_in
                       |=> state_reg == ST_STANDBY && cmd_ignored_out)
      else $error("invalid command not ignored");

endmodule
`default_nettype wire

/* tb/romc_host_model.sv */
// Host model that sends command strobes as header and code byte pairs
`timescale 1ns/1ps
`default_nettype none
module romc_host_model
   import romc_pkg::*;
(
   // Clock
   input  wire logic       clk_in,
   // Byte stream to the device
   output logic            spi_cs_n_out,
   output logic            spi_byte_valid_out,
   output logic [7:0]      spi_byte_out
);
   initial begin
      spi_cs_n_out = 1'b1;
      spi_byte_valid_out = 1'b0;
      spi_byte_out = 8'h00;
   end
   task automatic send_cmd(input logic [7:0] code);
      @(posedge clk_in);
      spi_cs_n_out <= 1'b0;
      spi_byte_valid_out <= 1'b1;
      spi_byte_out <= CMD_HEADER;
      @(posedge clk_in);
      spi_byte_out <= code;
      @(posedge clk_in);
      spi_byte_valid_out <= 1'b0;
      // Released byte inverted so stale data never looks valid
      spi_byte_out <= ~code;
      @(posedge clk_in);
      spi_cs_n_out <= 1'b1;
   endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the operating-mode controller
`timescale 1ns/1ps
`default_nettype none
module tb
   import romc_pkg::*;
;
   localparam int SU = 20;
   localparam int LT = 10;
   logic clk = 1'b0, nrst = 1'b0, shut = 1'b0, slock = 1'b0, txd = 1'b0, rxd = 1'b0, rxto = 1'b0;
   logic turn = 1'b0, ldcr = 1'b0, wake = 1'b0, ptx = 1'b0, prx = 1'b0, lowb = 1'b0, guard = 1'b0;
   logic [6:0] cal = 7'h00;
   logic       cs_n, bval;
   logic [7:0] bdat;
   logic [6:0] code, calr;
   logic       err, held, ign, sup, poe, xo, syn, wut, rxc, pa, calv;
   logic       saw_lock = 1'b0, saw_ign = 1'b0, saw_err = 1'b0;
   int         bad_count = 0;
   int         n_compared = 0;
   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (code === CODE_LOCK) saw_lock = 1'b1;
      if (ign === 1'b1) saw_ign = 1'b1;
      if (err !== 1'b0 && nrst) saw_err = 1'b1;
   end
   romc_host_model host (.clk_in(clk), .spi_cs_n_out(cs_n), .spi_byte_valid_out(bval), .spi_byte_out(bdat));
   romc_mode_ctrl #(.STARTUP_CYCLES(SU), .LOCK_TIMEOUT_CYCLES(LT)) uut (
      .clk_in(clk), .nrst_in(nrst), .shutdown_pin_in(shut),
      .spi_cs_n_in(cs_n), .spi_byte_valid_in(bval), .spi_byte_in(bdat),
      .synth_lock_in(slock), .tx_done_in(txd), .rx_done_in(rxd), .rx_timeout_in(rxto),
      .auto_turnaround_in(turn), .ldcr_mode_in(ldcr), .wakeup_in(wake),
      .pending_tx_in(ptx), .pending_rx_in(prx), .low_batt_in(lowb), .batt_guard_en_in(guard),
      .synth_cal_in(cal), .state_code_out(code), .state_error_out(err), .lock_held_out(held),
      .cmd_ignored_out(ign), .supply_on_out(sup), .pins_oe_out(poe), .crystal_osc_on_out(xo),
      .synth_on_out(syn), .wakeup_timer_on_out(wut), .rx_chain_on_out(rxc),
      .power_amplifier_on_out(pa), .synth_cal_result_out(calr), .synth_cal_valid_out(calv));
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Bounded wait for a state code
   task automatic wait_code(input logic [6:0] exp, input int limit);
      int n;
      n = 0;
      while (code !== exp && n < limit) begin
         ticks(1);
         n++;
      end
      check("state code", {1'b0, exp}, {1'b0, code});
   endtask
   // Sel: 0 wake, 1 tx done, 2 rx done, 3 turnaround, 4 rx timeout
   task automatic pulse(input int sel);
      @(posedge clk);
      wake <= (sel == 0);
      txd  <= (sel == 1);
      rxd  <= (sel == 2);
      turn <= (sel == 3);
      rxto <= (sel == 4);
      @(posedge clk);
      wake <= 1'b0;
      txd  <= 1'b0;
      rxd  <= 1'b0;
      turn <= 1'b0;
      rxto <= 1'b0;
   endtask
   task automatic t_up();
      check("startup code", 8'h00, {1'b0, code});
      wait_code(CODE_READY, SU + 10);
      check("pins driven", 8'h00, {7'h00, poe});
      check("crystal on", 8'h01, {7'h00, xo});
   endtask
   task automatic t_standby();
      host.send_cmd(CMD_STANDBY);
      wait_code(CODE_STANDBY, 10);
      saw_ign = 1'b0;
      host.send_cmd(CMD_TX);
      ticks(20);
      check("standby held", {1'b0, CODE_STANDBY}, {1'b0, code});
      check("tx in standby ignored", 8'h01, {7'h00, saw_ign});
      check("crystal off", 8'h00, {7'h00, xo});
      check("synth off", 8'h00, {7'h00, syn});
      host.send_cmd(CMD_READY);
      wait_code(CODE_READY, 10);
   endtask
   task automatic t_sleep();
      host.send_cmd(CMD_SLEEP);
      wait_code(CODE_SLEEP, 10);
      check("wake timer on", 8'h01, {7'h00, wut});
      pulse(0);
      wait_code(CODE_READY, 10);
      @(posedge clk);
      ptx <= 1'b1;
      slock <= 1'b1;
      host.send_cmd(CMD_SLEEP);
      wait_code(CODE_SLEEP, 10);
      pulse(0);
      ptx <= 1'b0;
      wait_code(CODE_TX, 20);
      pulse(1);
      wait_code(CODE_READY, 10);
   endtask
   task automatic t_tx();
      saw_lock = 1'b0;
      @(posedge clk);
      slock <= 1'b1;
      host.send_cmd(CMD_TX);
      wait_code(CODE_TX, 20);
      check("lock passed", 8'h01, {7'h00, saw_lock});
      check("pa on", 8'h01, {7'h00, pa});
      @(posedge clk);
      lowb <= 1'b1;
      guard <= 1'b1;
      ticks(3);
      check("pa off", 8'h00, {7'h00, pa});
      saw_ign = 1'b0;
      host.send_cmd(CMD_RX);
      ticks(3);
      check("rx in tx ignored", 8'h01, {7'h00, saw_ign});
      check("tx kept", {1'b0, CODE_TX}, {1'b0, code});
      host.send_cmd(CMD_ABORT);
      wait_code(CODE_READY, 10);
      @(posedge clk);
      lowb <= 1'b0;
      guard <= 1'b0;
   endtask
   task automatic t_rx();
      saw_lock = 1'b0;
      @(posedge clk);
      slock <= 1'b0;
      host.send_cmd(CMD_RX);
      wait_code(CODE_RX, LT + 10);
      check("lock passed", 8'h01, {7'h00, saw_lock});
      check("rx chain on", 8'h01, {7'h00, rxc});
      pulse(2);
      wait_code(CODE_READY, 10);
      saw_ign = 1'b0;
      host.send_cmd(CMD_ABORT);
      ticks(3);
      check("abort ignored", 8'h01, {7'h00, saw_ign});
      check("ready kept", {1'b0, CODE_READY}, {1'b0, code});
      // Automatic turnaround both ways, then receive timeout into sleep
      host.send_cmd(CMD_RX);
      wait_code(CODE_RX, LT + 10);
      pulse(3);
      wait_code(CODE_TX, LT + 10);
      check("pa on after turn", 8'h01, {7'h00, pa});
      pulse(3);
      wait_code(CODE_RX, LT + 10);
      @(posedge clk);
      ldcr <= 1'b1;
      pulse(4);
      wait_code(CODE_SLEEP, 10);
      @(posedge clk);
      ldcr <= 1'b0;
      host.send_cmd(CMD_READY);
      wait_code(CODE_READY, 10);
   endtask
   task automatic t_lock(input logic [7:0] c, input logic [6:0] w);
      @(posedge clk);
      slock <= 1'b0;
      cal <= w;
      host.send_cmd(c);
      wait_code(CODE_LOCK, LT + 10);
      ticks(3 * LT);
      check("lock held", {1'b0, CODE_LOCK}, {1'b0, code});
      check("held flag", 8'h01, {7'h00, held});
      check("synth on", 8'h01, {7'h00, syn});
      check("cal valid", 8'h01, {7'h00, calv});
      check("cal word", {1'b0, w}, {1'b0, calr});
      host.send_cmd(CMD_READY);
      wait_code(CODE_READY, 10);
   endtask
   task automatic t_shut();
      @(posedge clk);
      shut <= 1'b1;
      ticks(3);
      check("supply off", 8'h00, {7'h00, sup});
      check("pins floated", 8'h01, {7'h00, poe});
      check("cal word cleared", {1'b0, CAL_RESET}, {1'b0, calr});
      check("shutdown code", {1'b0, CODE_SHUTDOWN}, {1'b0, code});
      @(posedge clk);
      shut <= 1'b0;
      wait_code(CODE_READY, SU + 10);
      check("supply back", 8'h01, {7'h00, sup});
   endtask
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      ticks(1);
      t_up();
      t_standby();
      t_sleep();
      t_tx();
      t_rx();
      t_lock(CMD_LOCK_RX, 7'h5A);
      t_lock(CMD_LOCK_TX, 7'h25);
      t_shut();
      check("error flag", 8'h00, {7'h00, saw_err});
      finish_test();
   end
   initial begin
      #200000;
      bad_count++;
      finish_test();
   end
endmodule
`default_nettype wire
